// [shared/acc_regs.vh]
// Contract
// RL1: a conversion takes at least 35 system clock cycles from start to result
// RL2: sampling auto-zeroes the converter; conversion begins only after sampling ends
// RL3: result resolves upper four bits first, then lower four bits
// RL4: software configures setup register before writing the control register
// RL5: a start during a running conversion aborts it and starts afresh
// RL6: channel and offset changes take effect only at the next start
// RL7: enable bit low blocks conversions and all accesses except enable writes
// RL8: request value 0 does nothing; value 1 converts once then stops
// RL9: bits 2..0 choose channel 0..7 on the matching pin; reset selects 0
// RL10: software sets the matching port bit before using a pin as input
// RL11: setup bits 4..0 select no offset, 35 or 50 percent reference offset
// RL12: control bit 3 starts a conversion and self-clears on completion
// RL13: control bits 3 and 4 choose converter or digital port use
// RL14: result sits at bank C location A; undefined when enable was off
// RL15: the result register is read-only; writes leave it unchanged
// RL16: software points the register pointer at bank C before access
// RL17: an aborted conversion leaves the last completed result in place
// RL18: a one-cycle completion pulse coincides with the start bit clearing
`ifndef ACC_REGS_VH
`define ACC_REGS_VH

// register locations within expanded bank C
`define ACC_BANK_C          4'h_C
`define ACC_OFS_CONTROL     4'h_8
`define ACC_OFS_SETUP       4'h_9
`define ACC_OFS_RESULT      4'h_A

// field positions
`define ACC_CTL_START_BIT   3
`define ACC_CTL_MODE_BIT    4
`define ACC_SET_ENABLE_BIT  7

// reset values
`define ACC_CONTROL_RST     8'h_00
`define ACC_SETUP_RST       8'h_00

// offset codes in setup bits 4..0
`define ACC_OFFSET_NONE     5'h_00
`define ACC_OFFSET_35       5'h_01
`define ACC_OFFSET_50       5'h_02

// timing: sample phase, then two 4-bit steps, total 35 cycles
`define ACC_CONV_CYCLES     6'h_23
`define ACC_SAMPLE_CYCLES   6'h_0B
`define ACC_MSB_CYCLES      6'h_0C
`define ACC_LSB_CYCLES      6'h_0C

`endif

// [logic/acc_half_flash.v]
`timescale 1ns/10ps
`include "acc_regs.vh"

// two-step quantiser: upper nibble, then residue into lower nibble
module acc_half_flash
(
    // clock and reset
    input  wire       i_sys_clk,
    input  wire       i_rstn,
    // control
    input  wire       i_clear,
    input  wire       i_msb_strobe,
    input  wire       i_lsb_strobe,
    input  wire [7:0] i_sample,
    input  wire [4:0] i_offset,
    // result
    output reg  [7:0] o_code
);
    reg  [7:0] scaled;
    reg  [8:0] prod;

    // offset narrows the range: code maps the span above the raised floor
    always @*
    begin
        prod = 9'h_000;
        if (i_offset == `ACC_OFFSET_50)
            prod = (i_sample < 8'h_80) ? 9'h_000 : {i_sample - 8'h_80, 1'b0};
        else if (i_offset == `ACC_OFFSET_35)
            prod = (i_sample < 8'h_5A) ? 9'h_000
                 : {1'b0, i_sample - 8'h_5A} + {2'b00, i_sample[7:1]} - 9'h_02D;
        else
            prod = {1'b0, i_sample};
        scaled = prod[8] ? 8'h_FF : prod[7:0];
    end

    // coarse ladder then fine ladder
    always @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            o_code <= 8'h_00;
        else if (i_clear)
            o_code <= 8'h_00;
        else if (i_msb_strobe)
            o_code <= {scaled[7:4], 4'h_0}; // RL3
        else if (i_lsb_strobe)
            o_code <= {o_code[7:4], scaled[3:0]}; // RL3
    end
endmodule // acc_half_flash

// [logic/acc_conv_ctrl.v]
`timescale 1ns/10ps
`include "acc_regs.vh"

module acc_conv_ctrl
(
    // clock and reset
    input  wire       i_sys_clk,
    input  wire       i_rstn,
    // register port inside the expanded register space
    input  wire [3:0] i_bank,
    input  wire [3:0] i_addr,
    input  wire       i_wr,
    input  wire       i_rd,
    input  wire [7:0] i_wdata,
    output reg  [7:0] o_rdata,
    // analog side: digitised level of each second_port pin
    input  wire [63:0] i_pin_level,
    // status
    output reg        o_busy,
    output reg        o_done,
    output reg  [7:0] o_analog_sel,
    output reg  [4:0] o_ref_offset,
    output reg        o_conv_enable
);
    localparam ST_IDLE   = 2'd0;
    localparam ST_SAMPLE = 2'd1;
    localparam ST_MSB    = 2'd2;
    localparam ST_LSB    = 2'd3;

    reg  [7:0] control_q;
    reg  [7:0] setup_q;
    reg  [7:0] result_q;
    reg  [1:0] state_q;
    reg  [5:0] cnt_q;
    reg  [2:0] act_chan_q;
    reg  [4:0] act_ofs_q;
    reg  [7:0] sample_q;
    reg        msb_stb_q;
    reg        lsb_stb_q;
    wire [7:0] code;

    function hit;
        input [3:0] bank;
        input [3:0] addr;
        input [3:0] ofs;
        begin
            hit = (bank == `ACC_BANK_C) && (addr == ofs);
        end
    endfunction

    wire en        = setup_q[`ACC_SET_ENABLE_BIT];
    wire wr_ctl    = i_wr && hit(i_bank, i_addr, `ACC_OFS_CONTROL) && en; // RL7
    wire wr_set    = i_wr && hit(i_bank, i_addr, `ACC_OFS_SETUP);
    // a start is bit 3 with bit 4 clear; bit 4 keeps the pin digital
    wire start     = wr_ctl && i_wdata[`ACC_CTL_START_BIT]
                     && !i_wdata[`ACC_CTL_MODE_BIT]; // RL8 RL13
    wire finish    = (state_q == ST_LSB) && (cnt_q == 6'h_00);

    // control register: start bit self-clears on completion
    always @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            control_q <= `ACC_CONTROL_RST; // RL9
        else if (wr_ctl)
        begin
            control_q                     <= i_wdata;
            // start bit sticks only when a conversion really begins, else polling would hang
            control_q[`ACC_CTL_START_BIT] <= start; // RL12 RL13
        end
        else if (finish || !en)
            control_q[`ACC_CTL_START_BIT] <= 1'b0; // RL12
    end

    // setup register; the enable bit is always writable
    always @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            setup_q <= `ACC_SETUP_RST;
        else if (wr_set && en)
            setup_q <= i_wdata;
        else if (wr_set)
            setup_q[`ACC_SET_ENABLE_BIT] <= i_wdata[`ACC_SET_ENABLE_BIT]; // RL7
    end

    // sequencer: sample, coarse, fine; restart aborts any phase
    always @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            state_q    <= ST_IDLE;
            cnt_q      <= 6'h_00;
            act_chan_q <= 3'h_0;
            act_ofs_q  <= 5'h_00;
            sample_q   <= 8'h_00;
            msb_stb_q  <= 1'b0;
            lsb_stb_q  <= 1'b0;
        end
        else
        begin
            msb_stb_q <= 1'b0;
            lsb_stb_q <= 1'b0;
            if (!en)
                state_q <= ST_IDLE; // RL7
            else if (start)
            begin
                state_q    <= ST_SAMPLE; // RL5
                cnt_q      <= `ACC_SAMPLE_CYCLES - 6'h_01;
                act_chan_q <= i_wdata[2:0]; // RL6 RL9
                act_ofs_q  <= setup_q[4:0]; // RL6 RL11
            end
            else
            begin
                case (state_q)
                    ST_SAMPLE:
                    begin
                        // converter auto-zeroes while the input settles
                        sample_q <= i_pin_level[act_chan_q*8 +: 8]; // RL2
                        if (cnt_q == 6'h_00)
                        begin
                            state_q   <= ST_MSB; // RL2
                            cnt_q     <= `ACC_MSB_CYCLES - 6'h_01;
                            msb_stb_q <= 1'b1;
                        end
                        else
                            cnt_q <= cnt_q - 6'h_01;
                    end
                    ST_MSB:
                    begin
                        if (cnt_q == 6'h_00)
                        begin
                            state_q   <= ST_LSB;
                            cnt_q     <= `ACC_LSB_CYCLES - 6'h_01;
                            lsb_stb_q <= 1'b1;
                        end
                        else
                            cnt_q <= cnt_q - 6'h_01;
                    end
                    ST_LSB:
                    begin
                        if (cnt_q == 6'h_00)
                            state_q <= ST_IDLE; // RL1 RL8
                        else
                            cnt_q <= cnt_q - 6'h_01;
                    end
                    default:
                        state_q <= ST_IDLE;
                endcase
            end
        end
    end

    acc_half_flash u_flash
    (
        .i_sys_clk    (i_sys_clk),
        .i_rstn       (i_rstn),
        .i_clear      (start),
        .i_msb_strobe (msb_stb_q),
        .i_lsb_strobe (lsb_stb_q),
        .i_sample     (sample_q),
        .i_offset     (act_ofs_q),
        .o_code       (code)
    );

    // result only updates on completion, so an abort keeps the old value
    always @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            result_q <= 8'h_00;
        else if (finish && !start && en)
            result_q <= code; // RL14 RL15 RL17
    end

    // read data; with the converter disabled the result reads as all ones (floating output), control and setup as zero
    always @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            o_rdata <= 8'h_00;
        else if (!i_rd)
            o_rdata <= 8'h_00;
        else if (hit(i_bank, i_addr, `ACC_OFS_CONTROL) && en)
            o_rdata <= control_q;
        else if (hit(i_bank, i_addr, `ACC_OFS_SETUP) && en)
            o_rdata <= setup_q; // RL7
        else if (hit(i_bank, i_addr, `ACC_OFS_RESULT))
            o_rdata <= en ? result_q : 8'h_FF; // RL7 RL14
        else
            o_rdata <= 8'h_00;
    end

    // status outputs, all registered
    always @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_busy        <= 1'b0;
            o_done        <= 1'b0;
            o_analog_sel  <= 8'h_00;
            o_ref_offset  <= 5'h_00;
            o_conv_enable <= 1'b0;
        end
        else
        begin
            o_busy        <= control_q[`ACC_CTL_START_BIT];
            o_done        <= finish && !start && en; // RL18
            o_analog_sel  <= control_q[`ACC_CTL_MODE_BIT] ? 8'h_00
                             : (8'h_01 << control_q[2:0]); // RL13
            o_ref_offset  <= act_ofs_q;
            o_conv_enable <= en;
        end
    end
endmodule // acc_conv_ctrl

// [bench/acc_pin_src.sv]
`timescale 1ns/10ps
module acc_pin_src
(
    // digitised level of each second_port pin, channel n in byte n
    output wire [63:0] o_level
);
    // distinct levels, so a wrong channel pick gives a wrong code
    assign o_level = 64'h_F0E1_D2C3_B4A5_9687;
endmodule // acc_pin_src

// [bench/acc_conv_ctrl_checker.sv]
`timescale 1ns/10ps
module acc_chk
(
    // clock and reset
    input wire       i_sys_clk,
    input wire       i_rstn,
    // register port
    input wire [3:0] i_bank,
    input wire [3:0] i_addr,
    input wire       i_wr,
    input wire       i_rd,
    input wire [7:0] i_wdata,
    input wire [7:0] o_rdata,
    // status
    input wire       o_busy,
    input wire       o_done,
    input wire [7:0] o_analog_sel,
    input wire [4:0] o_ref_offset,
    input wire       o_conv_enable
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rstn);
    // accepted control write; enable is seen one cycle late, so keep writes spaced
    wire ctl_wr   = i_wr && i_bank == 4'h_C && i_addr == 4'h_8 && o_conv_enable;
    wire start_ok = ctl_wr && i_wdata[3] && !i_wdata[4];
    reg  [5:0] cnt_q;
    // cycles since the last accepted start, saturating
    always @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            cnt_q <= 6'h3F;
        else if (start_ok)
            cnt_q <= 6'h01;
        else if (cnt_q != 6'h3F)
            cnt_q <= cnt_q + 6'h01;
    end
    AST_DONE_PULSE: assert property (o_done |=> !o_done)
        else $error("done pulse longer than one cycle");
    AST_DONE_BUSY: assert property (o_done |=> $fell(o_busy))
        else $error("done without busy falling");
    AST_LATENCY: assert property (o_done |-> cnt_q == 6'h24)
        else $error("conversion time wrong");
    AST_BUSY: assert property (start_ok |-> ##2 o_busy)
        else $error("start did not raise busy");
    AST_OFS_HELD: assert property (o_busy && cnt_q > 6'h03 |-> $stable(o_ref_offset))
        else $error("offset moved during conversion");
    AST_OFF: assert property (i_wr && i_bank == 4'h_C && i_addr == 4'h_8
        && !o_conv_enable && !o_busy |-> ##2 !o_busy)
        else $error("disabled converter started");
    AST_RES_OFF: assert property (i_rd && i_bank == 4'h_C && i_addr == 4'h_A && !o_conv_enable
        |=> o_conv_enable || o_rdata == 8'hFF)
        else $error("disabled result read not all ones");
    AST_IDLE_RD: assert property (!i_rd |=> o_rdata == 8'h00)
        else $error("read data without read");
    AST_DIGITAL: assert property (ctl_wr && i_wdata[4] |-> ##2 o_analog_sel == 8'h00)
        else $error("digital mode left a pin analog");
    AST_ONEHOT: assert property ($onehot0(o_analog_sel))
        else $error("more than one analog pin");
    cover property (o_done);
    cover property (start_ok && o_busy);
    cover property (i_rd && !o_conv_enable);
endmodule // acc_chk
bind acc_conv_ctrl acc_chk u_chk (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_bank(i_bank),
    .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd), .i_wdata(i_wdata), .o_rdata(o_rdata),
    .o_busy(o_busy), .o_done(o_done), .o_analog_sel(o_analog_sel),
    .o_ref_offset(o_ref_offset), .o_conv_enable(o_conv_enable));

// [bench/tb.sv]
`timescale 1ns/10ps
module tb;
    reg         i_sys_clk = 1'b0;
    reg         i_rstn    = 1'b0;
    reg  [3:0]  i_bank    = 4'h_C;
    reg  [3:0]  i_addr    = 4'h_0;
    reg         i_wr      = 1'b0;
    reg         i_rd      = 1'b0;
    reg  [7:0]  i_wdata   = 8'h00;
    wire [63:0] lvl;
    wire [7:0]  rdata;
    wire [7:0]  sel;
    wire [4:0]  ofs;
    wire        busy;
    wire        done;
    wire        en;
    integer     failures = 0;
    integer     checks   = 0;
    integer     cyc      = 0;
    integer     n;
    integer     k;
    reg  [7:0]  d;
    // rows: channel, offset code, expected code (unchecked for the 35 percent code)
    localparam [15:0] ROWS [0:9] = '{16'h_4100, 16'h_A2A4, 16'h_0087, 16'h_2096,
        16'h_40A5, 16'h_60B4, 16'h_80C3, 16'h_A0D2, 16'h_C0E1, 16'h_E0F0};
    acc_pin_src src (.o_level(lvl));
    acc_conv_ctrl uut (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_bank(i_bank),
        .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd), .i_wdata(i_wdata), .o_rdata(rdata),
        .i_pin_level(lvl), .o_busy(busy), .o_done(done), .o_analog_sel(sel),
        .o_ref_offset(ofs), .o_conv_enable(en));
    initial
    begin
        forever #2.5 i_sys_clk = ~i_sys_clk;
    end
    task chk(input [7:0] seen, input [7:0] exp, input string name);
        begin
            checks = checks + 1;
            if (seen !== exp)
            begin
                failures = failures + 1;
                $display("unexpected %s expected %h seen %h", name, exp, seen);
            end
        end
    endtask
    // one write strobe, sampled at the second edge
    task wr(input [3:0] a, input [7:0] v);
        begin
            @(posedge i_sys_clk);
            i_addr <= a;
            i_wdata <= v;
            i_wr <= 1'b1;
            @(posedge i_sys_clk);
            i_wr <= 1'b0;
        end
    endtask
    task rd(input [3:0] a);
        begin
            @(posedge i_sys_clk);
            i_addr <= a;
            i_rd <= 1'b1;
            @(posedge i_sys_clk);
            i_rd <= 1'b0;
            #1 d = rdata;
        end
    endtask
    // start and count edges until done, bounded
    task conv(input [7:0] v);
        begin
            wr(4'h_8, v);
            n = 0;
            while (n < 60 && done !== 1'b1)
            begin
                @(posedge i_sys_clk);
                #1 n = n + 1;
            end
        end
    endtask
    task idle3(input [7:0] exp, input string name);
        begin
            repeat (3) @(posedge i_sys_clk);
            #1 chk(sel, exp, name);
            chk({7'h0, busy}, 8'h00, name);
        end
    endtask
    task close_out;
        begin
            if (failures == 0 && checks > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask
    // hang guard
    always @(posedge i_sys_clk)
    begin
        cyc = cyc + 1;
        if (cyc == 5000)
        begin
            failures = failures + 1;
            close_out;
        end
    end
    initial
    begin
        repeat (6) @(posedge i_sys_clk);
        i_rstn <= 1'b1;
        #1 chk(rdata | sel | {3'h0, ofs} | {5'h0, busy, done, en}, 8'h00, "reset");
        wr(4'h_8, 8'h08);
        idle3(8'h01, "disabled");
        rd(4'h_A);
        chk(d, 8'hFF, "disabled result");
        wr(4'h_9, 8'h80);
        for (k = 0; k < 10; k = k + 1)
        begin
            wr(4'h_9, {3'b100, ROWS[k][12:8]});
            conv({5'h01, ROWS[k][15:13]});
            chk(n[7:0], 8'd35, "latency");
            chk(sel, 8'h01 << ROWS[k][15:13], "pin");
            chk({3'h0, ofs}, {3'h0, ROWS[k][12:8]}, "offset");
            rd(4'h_8);
            chk(d, {5'h00, ROWS[k][15:13]}, "control");
            rd(4'h_A);
            if (ROWS[k][12:8] != 5'h01)
                chk(d, ROWS[k][7:0], "result");
        end
        wr(4'h_A, 8'h55);
        rd(4'h_A);
        chk(d, 8'hF0, "result write");
        wr(4'h_8, 8'h02);
        idle3(8'h04, "no action");
        wr(4'h_8, 8'h1B);
        idle3(8'h00, "digital");
        i_bank <= 4'h_0;
        wr(4'h_8, 8'h08);
        i_bank <= 4'h_C;
        idle3(8'h00, "other bank");
        wr(4'h_8, 8'h08);
        repeat (10) @(posedge i_sys_clk);
        wr(4'h_9, 8'h82);
        repeat (2) @(posedge i_sys_clk);
        #1 chk({3'h0, ofs}, 8'h00, "held offset");
        wr(4'h_9, 8'h80);
        rd(4'h_A);
        chk(d, 8'hF0, "kept result");
        conv(8'h0A);
        chk(n[7:0], 8'd35, "restart");
        rd(4'h_A);
        chk(d, 8'hA5, "restart result");
        close_out;
    end
endmodule // tb
